// ### design/pgq_params.svh
// Constants for the power-good qualifier: command code, field positions, timing
`ifndef PGQ_PARAMS_SVH
`define PGQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Command code of the settings word
// ----------------------------------------------------------------------
`define PGQ_CMD_SETTINGS      8'hE3

// ----------------------------------------------------------------------
// Field positions inside the settings word
// ----------------------------------------------------------------------
`define PGQ_FALL_HI           15
`define PGQ_FALL_LO           12
`define PGQ_RISE_HI           11
`define PGQ_RISE_LO           8
`define PGQ_MASK_HI           7
`define PGQ_MASK_LO           0
`define PGQ_BIT_OV_FAULT      7
`define PGQ_BIT_OV_WARN       6
`define PGQ_BIT_UV_FAULT      5
`define PGQ_BIT_UV_WARN       4
`define PGQ_BIT_OC_WARN       3
`define PGQ_BIT_OC_FAULT      2
`define PGQ_BIT_IN_OV_WARN    1
`define PGQ_BIT_IN_OV_FAULT   0

// ----------------------------------------------------------------------
// Widths, reset value and delay timing
// ----------------------------------------------------------------------
`define PGQ_REG_W             16
`define PGQ_EVT_W             8
`define PGQ_CNT_W             17
`define PGQ_SETTINGS_RESET    16'h0000
`define PGQ_DELAY_ZERO_TICKS  17'h00001
`define PGQ_DELAY_BASE        17'h00001
`define PGQ_DELAY_EXTRA       17'h00001
`define PGQ_CNT_ZERO          17'h00000
`define PGQ_CNT_ONE           17'h00001

`endif

// ### design/pgq_pkg.sv
// Types shared by the power-good qualifier and its users
package pgq_pkg;

    // ------------------------------------------------------------------
    // Converter phase as reported by the sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_DISABLED   = 3'b000,    // Conversion off
        PH_ON_WAIT    = 3'b001,    // turn_on_wait
        PH_ON_RAMP    = 3'b010,    // turn_on_ramp
        PH_REGULATING = 3'b011,    // Normal regulation
        PH_OFF_RAMP   = 3'b100,    // turn_off_ramp
        PH_FAULT_OFF  = 3'b101     // Fault shutdown or hiccup delay
    } pgq_phase_t;

    // ------------------------------------------------------------------
    // Command request from the serial command decoder
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;        // One-cycle request strobe
        logic        write;        // 1 write word, 0 read word
        logic [7:0]  code;         // Command code
        logic [15:0] wdata;        // Write word
    } pgq_cmd_t;

    // ------------------------------------------------------------------
    // Answer to a command
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        ack;          // Request accepted
        logic        err;          // Request refused
        logic [15:0] rdata;        // Read word
    } pgq_rsp_t;

endpackage

// ### design/pgq_power_good_qualifier.sv
// Power-good qualifier: settings word, fall and rise delay timers, output
`timescale 1ns/1ns
`default_nettype none
`include "pgq_params.svh"

module pgq_power_good_qualifier #(
    parameter logic [15:0] SETTINGS_RESET = `PGQ_SETTINGS_RESET
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire pgq_pkg::pgq_cmd_t    cmdReq,
    output pgq_pkg::pgq_rsp_t         cmdRsp,
    input  wire logic                 nvmLoad,
    input  wire logic [15:0]          nvmData,
    input  wire logic                 convEnable,
    input  wire pgq_pkg::pgq_phase_t  phase,
    input  wire logic                 pwmTick,
    input  wire logic [7:0]           eventIn,
    input  wire logic [7:0]           continueOn,
    output logic                      powerGoodOut,
    output logic [15:0]               settingsOut
);

    // ------------------------------------------------------------------
    // Delay decode: 0 gives one tick, N gives 2^N+1 ticks
    // ------------------------------------------------------------------
    function automatic logic [`PGQ_CNT_W-1:0] delayTicks(input logic [3:0] n);
        logic [`PGQ_CNT_W-1:0] t;
        t = `PGQ_DELAY_ZERO_TICKS;
        if (n != 4'h0) begin
            t = (`PGQ_DELAY_BASE << n) + `PGQ_DELAY_EXTRA;
        end
        return t;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0]           settings_q;   // Settings word
    logic [`PGQ_CNT_W-1:0] fallCnt_q;    // Event duration in ticks
    logic [`PGQ_CNT_W-1:0] riseCnt_q;    // Clear duration in ticks
    logic                  bad_q;        // Qualified bad condition
    logic                  pg_q;         // Output flop
    pgq_pkg::pgq_rsp_t     rsp_q;        // Command answer

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic        hitCode   = cmdReq.valid && (cmdReq.code == `PGQ_CMD_SETTINGS);
    wire logic        wrOk      = hitCode && cmdReq.write && !convEnable;
    wire logic        rdOk      = hitCode && !cmdReq.write;
    wire logic        reqErr    = cmdReq.valid && !(wrOk || rdOk);
    wire logic [7:0]  maskBits  = settings_q[`PGQ_MASK_HI:`PGQ_MASK_LO];
    // A set mask bit blocks its event; continue-on faults never count
    wire logic [7:0]  liveEvt   = eventIn & ~maskBits & ~continueOn;
    wire logic        evtNow    = |liveEvt;
    wire logic [`PGQ_CNT_W-1:0] fallTgt =
        delayTicks(settings_q[`PGQ_FALL_HI:`PGQ_FALL_LO]);
    wire logic [`PGQ_CNT_W-1:0] riseTgt =
        delayTicks(settings_q[`PGQ_RISE_HI:`PGQ_RISE_LO]);
    wire logic        fallDone  = evtNow && (fallCnt_q >= fallTgt);
    wire logic        riseDone  = !evtNow && (riseCnt_q >= riseTgt);
    wire logic        regul     = (phase == pgq_pkg::PH_REGULATING);
    // Any non-regulating phase forces low at once, bypassing fall delay
    wire logic        forceLow  = !regul;

    logic bad_d;                         // Next qualified bad condition
    always_comb begin
        bad_d = bad_q;
        if (forceLow) begin
            bad_d = 1'b1;                // Forced phases
        end else if (fallDone) begin
            bad_d = 1'b1;                // Fall delay expired
        end else if (riseDone) begin
            bad_d = 1'b0;                // Rise delay expired
        end
    end
    wire logic pg_d = regul && !bad_d;

    // ------------------------------------------------------------------
    // Settings word; NVM restore wins over a host write
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            settings_q <= SETTINGS_RESET;
        end else if (nvmLoad) begin
            settings_q <= nvmData;
        end else if (wrOk) begin
            settings_q <= cmdReq.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Command answer, one cycle after the request
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.ack <= wrOk || rdOk;
            rsp_q.err <= reqErr;
            if (rdOk) begin
                rsp_q.rdata <= settings_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fall timer: counts ticks while an event stands, zero otherwise.
    // Kept apart from the rise timer so a short glitch never lowers pg.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !evtNow) begin
            fallCnt_q <= `PGQ_CNT_ZERO;
        end else if (pwmTick && (fallCnt_q < fallTgt)) begin
            fallCnt_q <= fallCnt_q + `PGQ_CNT_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Rise timer: counts ticks while clear, zero on any event.
    // Held at zero outside regulation, so entering regulation waits out
    // the full rise delay instead of releasing pg at once.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || evtNow || !regul) begin
            riseCnt_q <= `PGQ_CNT_ZERO;
        end else if (pwmTick && (riseCnt_q < riseTgt)) begin
            riseCnt_q <= riseCnt_q + `PGQ_CNT_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Qualified state and output flop
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            bad_q <= 1'b1;
            pg_q  <= 1'b0;
        end else begin
            bad_q <= bad_d;
            pg_q  <= pg_d;
        end
    end

    assign powerGoodOut = pg_q;
    assign settingsOut  = settings_q;
    assign cmdRsp       = rsp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    fall_expire_a: assert property (@(posedge clk) disable iff (rst)
        (regul && fallDone) |=> !powerGoodOut)
        else $error("pg not low after fall delay");

    rise_release_a: assert property (@(posedge clk) disable iff (rst)
        (regul && $past(regul) && riseDone && bad_q) |=> powerGoodOut)
        else $error("pg not released after rise delay");

    ov_masks_a: assert property (@(posedge clk) disable iff (rst)
        (maskBits[`PGQ_BIT_OV_FAULT] && maskBits[`PGQ_BIT_OV_WARN]
         && ((eventIn & ~8'hC0) == 8'h00)) |-> !evtNow)
        else $error("masked overvoltage event counted");

    uv_masks_a: assert property (@(posedge clk) disable iff (rst)
        (!maskBits[`PGQ_BIT_UV_FAULT] && eventIn[`PGQ_BIT_UV_FAULT]
         && !continueOn[`PGQ_BIT_UV_FAULT]) |=> (fallCnt_q != `PGQ_CNT_ZERO)
         || !$past(pwmTick))
        else $error("unmasked undervoltage fault not timed");

    oc_masks_a: assert property (@(posedge clk) disable iff (rst)
        (maskBits[`PGQ_BIT_OC_WARN] && maskBits[`PGQ_BIT_OC_FAULT]
         && ((eventIn & ~8'h0C) == 8'h00)) |=> (fallCnt_q == `PGQ_CNT_ZERO))
        else $error("masked overcurrent event timed");

    inov_masks_a: assert property (@(posedge clk) disable iff (rst)
        (maskBits[`PGQ_BIT_IN_OV_WARN] && maskBits[`PGQ_BIT_IN_OV_FAULT]
         && ((eventIn & ~8'h03) == 8'h00)) |-> !evtNow)
        else $error("masked input overvoltage event counted");

    forced_low_a: assert property (@(posedge clk) disable iff (rst)
        !regul |=> !powerGoodOut)
        else $error("pg high outside regulation");

    off_bypass_a: assert property (@(posedge clk) disable iff (rst)
        (phase == pgq_pkg::PH_OFF_RAMP || phase == pgq_pkg::PH_FAULT_OFF)
        ##1 1'b1 |-> !powerGoodOut && bad_q)
        else $error("fall delay not bypassed");

    cont_fault_a: assert property (@(posedge clk) disable iff (rst)
        ((eventIn & ~continueOn) == 8'h00) |-> !evtNow)
        else $error("continue-on fault counted");

    timers_apart_a: assert property (@(posedge clk) disable iff (rst)
        !((fallCnt_q != `PGQ_CNT_ZERO) && (riseCnt_q != `PGQ_CNT_ZERO)))
        else $error("both timers running");

    short_event_a: assert property (@(posedge clk) disable iff (rst)
        ($fell(powerGoodOut) && $past(regul) && regul) |-> $past(fallDone))
        else $error("pg fell without fall delay");

    locked_write_a: assert property (@(posedge clk) disable iff (rst)
        (convEnable && !nvmLoad) |=> $stable(settings_q))
        else $error("settings changed while converting");

    fall_restart_a: assert property (@(posedge clk) disable iff (rst)
        !evtNow |=> (fallCnt_q == `PGQ_CNT_ZERO))
        else $error("fall timer not restarted");

endmodule
`default_nettype wire

// ### bench/pgq_supervisor_model.sv
// Supervisor model: counts power-good drops seen on the output
`timescale 1ns/1ns
`default_nettype none
module pgq_supervisor_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       powerGood,
    output logic [7:0]      dropCount
);
    logic prevGood_q;    // Last sampled level
    // Every high-to-low step counts, so a glitch cannot hide
    always_ff @(posedge clk) begin
        if (rst) begin
            prevGood_q <= 1'b0;
            dropCount  <= 8'h00;
        end else begin
            prevGood_q <= powerGood;
            if (prevGood_q && !powerGood) begin
                dropCount <= dropCount + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the power-good qualifier
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    pgq_pkg::pgq_cmd_t   cmdReq = '0;
    pgq_pkg::pgq_rsp_t   cmdRsp;
    logic                nvmLoad = 1'b0;
    logic [15:0]         nvmData = 16'h0000;
    logic                convEnable = 1'b0;
    pgq_pkg::pgq_phase_t phase = pgq_pkg::PH_DISABLED;
    logic                pwmTick = 1'b1;     // Fast tick keeps delays short
    logic [7:0]          eventIn = 8'h00;
    logic [7:0]          continueOn = 8'h00;
    logic                powerGoodOut;
    logic [15:0]         settingsOut;
    logic [7:0]          dropCount;          // Drops seen by the supervisor
    logic [7:0]          expDrops = 8'h00;   // Drops we intend to cause
    int                  failures = 0;
    int                  checks_done = 0;
    logic [31:0]         seed = 32'h8;
    logic [18:0]         expQ[$];            // {dataValid, ack, err, rdata}
    always #20 clk = ~clk;
    pgq_power_good_qualifier pgq_power_good_qualifier_inst (.clk(clk), .rst(rst),
        .cmdReq(cmdReq), .cmdRsp(cmdRsp), .nvmLoad(nvmLoad), .nvmData(nvmData),
        .convEnable(convEnable), .phase(phase), .pwmTick(pwmTick), .eventIn(eventIn),
        .continueOn(continueOn), .powerGoodOut(powerGoodOut), .settingsOut(settingsOut));
    pgq_supervisor_model pgq_supervisor_model_inst (.clk(clk), .rst(rst),
        .powerGood(powerGoodOut), .dropCount(dropCount));
    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pgIs(input logic v);
        @(negedge clk);
        check({18'h00000, powerGoodOut}, {18'h00000, v});
    endtask
    // Bounded wait for release; the rise delay here is short
    task automatic waitRise;
        repeat (40) begin
            @(negedge clk);
            if (powerGoodOut === 1'b1) break;
        end
        check({18'h00000, powerGoodOut}, 19'h00001);
    endtask
    // One-cycle request; the answer is noted before it is driven
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] d,
                       input logic ok, input logic [15:0] rd);
        expQ.push_back({!wr && ok, ok, !ok, rd});
        @(posedge clk);
        cmdReq <= '{1'b1, wr, code, d};
        @(posedge clk);
        cmdReq.valid <= 1'b0;
    endtask
    // Answers are compared as they appear, oldest note first
    always @(negedge clk) begin : rspMonitor
        logic [18:0] e;
        if (cmdRsp.ack === 1'b1 || cmdRsp.err === 1'b1) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 19'h7FFFF;
            if (e[18]) check({1'b1, cmdRsp}, e);
            else check({1'b0, cmdRsp.ack, cmdRsp.err, 16'h0000}, {e[18:16], 16'h0000});
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin : mainSeq
        pgq_pkg::pgq_phase_t offPh[5];
        offPh = '{pgq_pkg::PH_DISABLED, pgq_pkg::PH_ON_WAIT, pgq_pkg::PH_ON_RAMP,
                  pgq_pkg::PH_OFF_RAMP, pgq_pkg::PH_FAULT_OFF};
        cyc(4);
        rst <= 1'b0;
        @(negedge clk);
        check({3'h0, settingsOut}, 19'h00000);
        pgIs(1'b0);
        seed = xorshift(seed);
        cmd(1'b1, 8'hE3, seed[15:0], 1'b1, 16'h0000);
        cmd(1'b0, 8'hE3, 16'h0000, 1'b1, seed[15:0]);
        cmd(1'b0, 8'hE4, 16'h0000, 1'b0, 16'h0000);
        convEnable <= 1'b1;
        cmd(1'b1, 8'hE3, ~seed[15:0], 1'b0, 16'h0000);
        cmd(1'b0, 8'hE3, 16'h0000, 1'b1, seed[15:0]);
        convEnable <= 1'b0;
        // Fall delay 5 ticks, rise delay 3 ticks, nothing masked
        cmd(1'b1, 8'hE3, 16'h2100, 1'b1, 16'h0000);
        phase <= pgq_pkg::PH_REGULATING;
        waitRise();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            eventIn <= 8'h01 << i;
            cyc(3);
            pgIs(1'b1);
            cyc(7);
            pgIs(1'b0);
            expDrops++;
            @(posedge clk);
            eventIn <= 8'h00;
            waitRise();
            // Same event with its own mask set must be ignored
            cmd(1'b1, 8'hE3, 16'h2100 | (16'h0001 << i), 1'b1, 16'h0000);
            eventIn <= 8'h01 << i;
            cyc(12);
            pgIs(1'b1);
            @(posedge clk);
            eventIn <= 8'h00;
        end
        // Two short bursts: the fall timer must restart in between
        repeat (2) begin
            @(posedge clk);
            eventIn <= 8'h10;
            cyc(3);
            eventIn <= 8'h00;
        end
        cyc(8);
        pgIs(1'b1);
        // No switching ticks: an unmasked event must not be timed
        @(posedge clk);
        pwmTick <= 1'b0;
        eventIn <= 8'h10;
        cyc(12);
        pgIs(1'b1);
        @(posedge clk);
        eventIn <= 8'h00;
        pwmTick <= 1'b1;
        cyc(2);
        // Continue-operating response keeps the output up; bit 5 is unmasked
        @(posedge clk);
        continueOn <= 8'h20;
        eventIn <= 8'h20;
        cyc(12);
        pgIs(1'b1);
        @(posedge clk);
        eventIn <= 8'h00;
        continueOn <= 8'h00;
        // Longest fall delay: leaving regulation must bypass it
        cmd(1'b1, 8'hE3, 16'hF100, 1'b1, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            phase <= offPh[i];
            cyc(2);
            pgIs(1'b0);
            expDrops++;
            @(posedge clk);
            phase <= pgq_pkg::PH_REGULATING;
            cyc(2);
            pgIs(1'b0);
            waitRise();
            @(posedge clk);
        end
        // Restore word loads even while converting
        seed = xorshift(seed);
        convEnable <= 1'b1;
        nvmData <= seed[15:0];
        nvmLoad <= 1'b1;
        @(posedge clk);
        nvmLoad <= 1'b0;
        cyc(1);
        @(negedge clk);
        check({3'h0, settingsOut}, {3'h0, seed[15:0]});
        check({11'h000, dropCount}, {11'h000, expDrops});
        check(19'(expQ.size()), 19'h00000);
        report_and_stop();
    end
    // Watchdog far beyond the expected run of under a thousand cycles
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
